//--- hw/uas_top.sv
/*
  Serial transceiver: queues, flow control, modem inputs, break, timeout, infrared.
  Assumes static configuration and asynchronous pins.
*/
`include "uas_map.svh"

// What this block does
// - Transmit sends start bit, data bits, then stop bits.
// - Optional parity added on transmit, checked on receive.
// - Five to eight data bits, parity optional, one or two stops.
// - Legacy and queued modes; reset comes up in legacy.
// - Device clock drives a programmable bit-rate divider.
// - Transmit queue 8 bits by 36.
// - Receive queue 11 bits by 36, character in low byte.
// - Queued entries flag break, framing, parity in bits 10,9,8.
// - DMA requests for transmit and receive.
// - Modem inputs sampled and reported.
// - Timeout when stream stops with data unread.
// - Flow control: RTS shows room, CTS off holds transmit.
// - Infrared zeros are 3/16 or 4/16 pulses, both ways.
module uas_top #(
  parameter int TX_DEPTH = `UAS_TX_DEPTH,
  parameter int RX_DEPTH = `UAS_RX_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration
  input wire uas_pkg::uas_cfg_type cfg,
  // Transmit character stream
  input wire logic tx_valid,
  input wire logic [`UAS_TX_WIDTH-1:0] tx_data,
  output logic tx_ready,
  // Receive entry stream
  output logic rx_valid,
  output logic [`UAS_RX_WIDTH-1:0] rx_data,
  input wire logic rx_ready,
  // DMA requests
  output logic tx_dma_req,
  output logic rx_dma_req,
  // Status
  output logic rx_timeout,
  output logic rx_overrun,
  output logic line_err,
  input wire logic err_clr,
  output logic [3:0] modem_status,
  output logic tx_busy,
  // Serial pins
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  output logic rts_n
);

  localparam int TPW = $clog2(TX_DEPTH);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam int RPW = $clog2(RX_DEPTH);
  localparam int RCW = $clog2(RX_DEPTH + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bit tick

  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [15:0] div_cnt;
  logic tick;

  // Two flops per pin; only sync2 is read by logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= `UAS_SYNC_RESET;
      sync2 <= `UAS_SYNC_RESET;
    end else begin
      sync1 <= {ri_n, dcd_n, dsr_n, cts_n, rxd};
      sync2 <= sync1;
    end
  end

  // Sixteen ticks a bit; divisor 0 is the fastest rate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
    end
  end
  assign tick = (div_cnt >= cfg.baud_div);

  // Frame geometry from the configuration
  logic [3:0] nbits;
  logic [3:0] frame_bits;
  logic [7:0] frame_ticks;
  logic [7:0] data_mask;
  assign nbits = 4'h5 + {2'h0, cfg.word_len};
  assign frame_bits = 4'h2 + nbits + {3'h0, cfg.parity_en} + {3'h0, cfg.stop2};
  assign frame_ticks = {frame_bits, 4'h0};
  assign data_mask = 8'hFF >> (2'h3 - cfg.word_len);

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit queue

  logic [`UAS_TX_WIDTH-1:0] tx_mem [TX_DEPTH];
  logic [TPW-1:0] tx_wp;
  logic [TPW-1:0] tx_rp;
  logic [TCW-1:0] tx_cnt;
  logic [TCW-1:0] next_tx_cnt;
  logic [TCW-1:0] tx_cap;
  logic tx_push;
  logic tx_pop;

  assign tx_cap = cfg.fifo_mode ? TCW'(TX_DEPTH) : TCW'(1);
  assign tx_push = tx_valid && tx_ready;
  assign next_tx_cnt = tx_cnt + TCW'(tx_push) - TCW'(tx_pop);

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
      tx_ready <= 1'b0;
      tx_dma_req <= 1'b0;
    end else begin
      if (tx_push) begin
        tx_wp <= (tx_wp == TPW'(TX_DEPTH - 1)) ? '0 : tx_wp + TPW'(1);
      end
      if (tx_pop) begin
        tx_rp <= (tx_rp == TPW'(TX_DEPTH - 1)) ? '0 : tx_rp + TPW'(1);
      end
      tx_cnt <= next_tx_cnt;
      tx_ready <= next_tx_cnt < tx_cap;
      tx_dma_req <= next_tx_cnt < tx_cap;
    end
  end

  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= tx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit serialiser

  uas_pkg::uas_tx_state_type tx_state;
  logic [3:0] tx_sub;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic tx_par;
  logic tx_cur;
  logic tx_hold;

  // CTS is checked only between characters
  assign tx_hold = cfg.flow_en && sync2[1];
  assign tx_pop = tick && (tx_state == uas_pkg::UAS_TX_IDLE) && (tx_cnt != '0) && !tx_hold;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_state <= uas_pkg::UAS_TX_IDLE;
      tx_sub <= 4'h0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      tx_par <= 1'b0;
      tx_cur <= `UAS_LINE_IDLE;
    end else if (tx_pop) begin
      tx_state <= uas_pkg::UAS_TX_START;
      tx_shift <= tx_mem[tx_rp] & data_mask;
      tx_par <= ^(tx_mem[tx_rp] & data_mask) ^ ~cfg.parity_even;
      tx_cur <= 1'b0;
      tx_sub <= 4'h0;
      tx_bit <= 3'h0;
    end else if (tick && tx_state != uas_pkg::UAS_TX_IDLE) begin
      tx_sub <= tx_sub + 4'h1;
      if (tx_sub == `UAS_SUB_LAST) begin
        unique case (tx_state)
          uas_pkg::UAS_TX_START: begin
            tx_state <= uas_pkg::UAS_TX_DATA;
            tx_cur <= tx_shift[0];
          end
          uas_pkg::UAS_TX_DATA: begin
            if ({1'b0, tx_bit} == nbits - 4'h1) begin
              tx_state <= cfg.parity_en ? uas_pkg::UAS_TX_PAR : uas_pkg::UAS_TX_STOP;
              tx_cur <= cfg.parity_en ? tx_par : 1'b1;
              tx_bit <= 3'h0;
            end else begin
              tx_shift <= tx_shift >> 1;
              tx_cur <= tx_shift[1];
              tx_bit <= tx_bit + 3'h1;
            end
          end
          uas_pkg::UAS_TX_PAR: begin
            tx_state <= uas_pkg::UAS_TX_STOP;
            tx_cur <= 1'b1;
          end
          uas_pkg::UAS_TX_STOP: begin
            if (cfg.stop2 && tx_bit == 3'h0) begin
              tx_bit <= 3'h1;
            end else begin
              tx_state <= uas_pkg::UAS_TX_IDLE;
            end
          end
          uas_pkg::UAS_TX_IDLE: begin
            tx_state <= uas_pkg::UAS_TX_IDLE;
          end
        endcase
      end
    end
  end

  // Infrared idles low; a zero bit opens with a short high pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txd <= `UAS_LINE_IDLE;
      tx_busy <= 1'b0;
    end else begin
      if (cfg.ir_en) begin
        txd <= (tx_state != uas_pkg::UAS_TX_IDLE) && !tx_cur &&
               (tx_sub < (cfg.ir_pulse4 ? `UAS_IR_LONG : `UAS_IR_SHORT));
      end else begin
        txd <= (tx_state == uas_pkg::UAS_TX_IDLE) ? `UAS_LINE_IDLE : tx_cur;
      end
      tx_busy <= (tx_state != uas_pkg::UAS_TX_IDLE) || (tx_cnt != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive line decode and break watch

  logic [3:0] ir_hold;
  logic rx_line;
  logic [15:0] low_cnt;

  // Pulse stretched to a whole bit: some jitter, simple decoder
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ir_hold <= 4'h0;
      low_cnt <= 16'h0000;
    end else begin
      if (tick) begin
        ir_hold <= sync2[0] ? `UAS_SUB_LAST : (ir_hold != 4'h0 ? ir_hold - 4'h1 : 4'h0);
        low_cnt <= rx_line ? 16'h0000 : (low_cnt == 16'hFFFF ? low_cnt : low_cnt + 16'h0001);
      end
    end
  end
  assign rx_line = cfg.ir_en ? !(sync2[0] || ir_hold != 4'h0) : sync2[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Receive deserialiser

  uas_pkg::uas_rx_state_type rx_state;
  logic [3:0] rx_sub;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic [7:0] rx_char;
  logic rx_pe;
  logic rx_push;
  logic rx_fe_now;
  logic rx_brk_now;
  logic [`UAS_RX_WIDTH-1:0] rx_entry;

  assign rx_char = rx_shift >> (2'h3 - cfg.word_len);
  assign rx_push = tick && ((rx_state == uas_pkg::UAS_RX_STOP && rx_sub == `UAS_SUB_MID && rx_line) ||
                            (rx_state == uas_pkg::UAS_RX_WAIT && rx_line));
  assign rx_fe_now = (rx_state == uas_pkg::UAS_RX_WAIT);
  assign rx_brk_now = rx_fe_now && (low_cnt > {8'h00, frame_ticks});
  // Flags are kept only in queued mode
  always_comb begin
    rx_entry = {3'h0, rx_char};
    rx_entry[`UAS_RX_BRK_BIT] = cfg.fifo_mode && rx_brk_now;
    rx_entry[`UAS_RX_FE_BIT] = cfg.fifo_mode && rx_fe_now;
    rx_entry[`UAS_RX_PE_BIT] = cfg.fifo_mode && rx_pe;
  end

  // Frame ends at mid-stop so an early next start is caught
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_state <= uas_pkg::UAS_RX_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_pe <= 1'b0;
    end else if (tick) begin
      rx_sub <= rx_sub + 4'h1;
      unique case (rx_state)
        uas_pkg::UAS_RX_IDLE: begin
          rx_sub <= 4'h0;
          rx_bit <= 3'h0;
          rx_pe <= 1'b0;
          if (!rx_line) begin
            rx_state <= uas_pkg::UAS_RX_START;
          end
        end
        uas_pkg::UAS_RX_START: begin
          if (rx_sub == `UAS_SUB_MID && rx_line) begin
            rx_state <= uas_pkg::UAS_RX_IDLE;
          end else if (rx_sub == `UAS_SUB_LAST) begin
            rx_state <= uas_pkg::UAS_RX_DATA;
          end
        end
        uas_pkg::UAS_RX_DATA: begin
          if (rx_sub == `UAS_SUB_MID) begin
            rx_shift <= {rx_line, rx_shift[7:1]};
          end else if (rx_sub == `UAS_SUB_LAST) begin
            rx_bit <= rx_bit + 3'h1;
            if ({1'b0, rx_bit} == nbits - 4'h1) begin
              rx_state <= cfg.parity_en ? uas_pkg::UAS_RX_PAR : uas_pkg::UAS_RX_STOP;
            end
          end
        end
        uas_pkg::UAS_RX_PAR: begin
          if (rx_sub == `UAS_SUB_MID) begin
            rx_pe <= rx_line != (^rx_char ^ ~cfg.parity_even);
          end else if (rx_sub == `UAS_SUB_LAST) begin
            rx_state <= uas_pkg::UAS_RX_STOP;
          end
        end
        uas_pkg::UAS_RX_STOP: begin
          if (rx_sub == `UAS_SUB_MID) begin
            rx_state <= rx_line ? uas_pkg::UAS_RX_IDLE : uas_pkg::UAS_RX_WAIT;
          end
        end
        uas_pkg::UAS_RX_WAIT: begin
          if (rx_line) begin
            rx_state <= uas_pkg::UAS_RX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive queue with registered head

  logic [`UAS_RX_WIDTH-1:0] rx_mem [RX_DEPTH];
  logic [RPW-1:0] rx_wp;
  logic [RPW-1:0] rx_rp;
  logic [RCW-1:0] rx_cnt;
  logic [RCW-1:0] rx_cap;
  logic out_free;
  logic rx_load;
  logic rx_bypass;
  logic rx_wr;
  logic rx_pop;

  // Head register is one entry; array holds one fewer
  assign rx_cap = cfg.fifo_mode ? RCW'(RX_DEPTH - 1) : RCW'(0);
  assign out_free = !rx_valid || rx_ready;
  assign rx_pop = rx_valid && rx_ready;
  assign rx_load = out_free && rx_cnt != '0;
  assign rx_bypass = out_free && rx_cnt == '0 && rx_push;
  assign rx_wr = rx_push && !rx_bypass && rx_cnt < rx_cap;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else begin
      if (rx_wr) begin
        rx_wp <= (rx_wp == RPW'(RX_DEPTH - 1)) ? '0 : rx_wp + RPW'(1);
      end
      if (rx_load) begin
        rx_rp <= (rx_rp == RPW'(RX_DEPTH - 1)) ? '0 : rx_rp + RPW'(1);
        rx_data <= rx_mem[rx_rp];
      end else if (rx_bypass) begin
        rx_data <= rx_entry;
      end
      rx_cnt <= rx_cnt + RCW'(rx_wr) - RCW'(rx_load);
      rx_valid <= rx_load || rx_bypass || (rx_valid && !rx_ready);
    end
  end

  always_ff @(posedge clk) begin
    if (rx_wr) begin
      rx_mem[rx_wp] <= rx_entry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status, timeout, flow control, modem and DMA

  logic [15:0] idle_cnt;
  logic [15:0] idle_lim;
  assign idle_lim = 16'(frame_ticks) * `UAS_TIMEOUT_FRAMES;

  // Sticky flags: a new event in the clearing cycle wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_overrun <= 1'b0;
      line_err <= 1'b0;
    end else begin
      rx_overrun <= (rx_push && !rx_bypass && !rx_wr) || (rx_overrun && !err_clr);
      line_err <= (rx_push && (rx_pe || rx_fe_now)) || (line_err && !err_clr);
    end
  end

  // Idle time counts while data waits; arrival or read restarts it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt <= 16'h0000;
      rx_timeout <= 1'b0;
    end else if (rx_push || rx_pop || !rx_valid || rx_state != uas_pkg::UAS_RX_IDLE) begin
      idle_cnt <= 16'h0000;
      rx_timeout <= 1'b0;
    end else if (tick) begin
      if (idle_cnt >= idle_lim) begin
        rx_timeout <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + 16'h0001;
      end
    end
  end

  // Margin leaves room for characters in flight
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rts_n <= 1'b1;
      modem_status <= 4'h0;
      rx_dma_req <= 1'b0;
    end else begin
      if (cfg.flow_en) begin
        rts_n <= cfg.fifo_mode ? (7'(rx_cnt) + `UAS_RTS_MARGIN >= 7'(rx_cap)) : rx_valid;
      end else begin
        rts_n <= !cfg.rts_force;
      end
      modem_status <= ~sync2[4:1];
      rx_dma_req <= rx_valid || rx_cnt != '0;
    end
  end

endmodule : uas_top

//--- hw/uas_map.svh
/*
  Constants of the serial transceiver: ticks, queue shapes, field positions, levels, counts.
  Assumes inclusion by bare name from the top module and the bench.
*/
`ifndef UAS_MAP_SVH
`define UAS_MAP_SVH

// Sixteen ticks a bit
`define UAS_SUB_MID 4'h7
`define UAS_SUB_LAST 4'hF
// Queue shapes
`define UAS_TX_WIDTH 8
`define UAS_TX_DEPTH 36
`define UAS_RX_WIDTH 11
`define UAS_RX_DEPTH 36
// Receive entry flag positions
`define UAS_RX_BRK_BIT 10
`define UAS_RX_FE_BIT 9
`define UAS_RX_PE_BIT 8
// Infrared pulse widths in ticks
`define UAS_IR_SHORT 4'h3
`define UAS_IR_LONG 4'h4
// Receive timeout gap in frames
`define UAS_TIMEOUT_FRAMES 16'h0004
// RTS margin in entries
`define UAS_RTS_MARGIN 7'h04
// Reset levels
`define UAS_LINE_IDLE 1'b1
`define UAS_SYNC_RESET 5'h1F

`endif

//--- hw/uas_pkg.sv
/*
  Types of the serial transceiver.
  Assumes uas_map.svh is on the include path.
*/
package uas_pkg;

  // Static configuration, held by the surrounding logic
  typedef struct packed {
    logic [15:0] baud_div;    // Tick period minus one, in clocks
    logic [1:0] word_len;     // 0..3 selects 5..8 data bits
    logic parity_en;
    logic parity_even;
    logic stop2;
    logic fifo_mode;          // Low selects the single-character legacy mode
    logic flow_en;
    logic rts_force;          // Request-to-send level while flow control is off
    logic ir_en;
    logic ir_pulse4;          // Infrared zero pulse of 4/16 instead of 3/16
  } uas_cfg_type;

  typedef enum logic [4:0] {
    UAS_TX_IDLE = 5'h01,
    UAS_TX_START = 5'h02,
    UAS_TX_DATA = 5'h04,
    UAS_TX_PAR = 5'h08,
    UAS_TX_STOP = 5'h10
  } uas_tx_state_type;

  typedef enum logic [5:0] {
    UAS_RX_IDLE = 6'h01,
    UAS_RX_START = 6'h02,
    UAS_RX_DATA = 6'h04,
    UAS_RX_PAR = 6'h08,
    UAS_RX_STOP = 6'h10,
    UAS_RX_WAIT = 6'h20
  } uas_rx_state_type;

endpackage : uas_pkg

//--- test/uas_top_checker.sv
/*
  Checker of the serial transceiver top, bound to it.
  Assumes one clock domain and a static configuration.
*/
module uas_top_checker #(
  parameter int TX_DEPTH = 36,
  parameter int RX_DEPTH = 36
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Streams and configuration
  input wire uas_pkg::uas_cfg_type cfg,
  input wire logic tx_ready,
  input wire logic tx_dma_req,
  input wire logic rx_valid,
  input wire logic [10:0] rx_data,
  input wire logic rx_ready,
  input wire logic rx_timeout,
  // Pins and modem status
  input wire logic [3:0] modem_status,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  input wire logic rts_n,
  input wire logic txd
);
  logic [20:0] high_run;
  logic [20:0] ir_limit;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////
  // Infrared high run against its limit
  assign ir_limit = (cfg.ir_pulse4 ? 21'h4 : 21'h3) * (21'(cfg.baud_div) + 21'h1);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      high_run <= 21'h0;
    end else begin
      high_run <= (cfg.ir_en && txd) ? high_run + 21'h1 : 21'h0;
    end
  end

  ////////////////////////////////
  // Port relations
  dma_mirror_a: assert property (tx_dma_req == tx_ready)
    else $error("tx dma differs");
  entry_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("unread entry changed");
  legacy_flags_a: assert property (!cfg.fifo_mode && rx_valid |-> rx_data[10:8] == 3'h0)
    else $error("flags in legacy entry");
  break_char_a: assert property (rx_valid && rx_data[10] |-> rx_data[7:0] == 8'h00)
    else $error("break with data");
  timeout_data_a: assert property (rx_timeout |-> rx_valid)
    else $error("timeout, no data");
  rts_forced_a: assert property ((!cfg.flow_en) [*4] |-> rts_n == !cfg.rts_force)
    else $error("rts not forced");
  rts_legacy_a: assert property ((cfg.flow_en && !cfg.fifo_mode && rx_valid) [*4] |-> rts_n)
    else $error("rts low, holder full");
  modem_track_a: assert property (
    $stable({ri_n, dcd_n, dsr_n, cts_n}) [*5] |-> modem_status == ~{ri_n, dcd_n, dsr_n, cts_n})
    else $error("modem status wrong");
  ir_pulse_a: assert property (cfg.ir_en && txd |-> high_run < ir_limit)
    else $error("ir pulse long");

  // Main scenarios reached
  cover property ($rose(rx_timeout));
  cover property (rx_valid && rx_data[10]);
  cover property ($fell(tx_ready));
endmodule : uas_top_checker

bind uas_top uas_top_checker #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) chk_i (
  .clk(clk), .resetn(resetn), .cfg(cfg), .tx_ready(tx_ready), .tx_dma_req(tx_dma_req),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .rx_timeout(rx_timeout),
  .modem_status(modem_status), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n),
  .rts_n(rts_n), .txd(txd)
);

//--- test/uas_remote.sv
/*
  Remote serial device: sends frames to rxd, captures frames from txd.
  Assumes bench-built frames, BIT_CLKS clocks a bit.
*/
module uas_remote #(
  parameter int BIT_CLKS = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sender: bits after the start bit, LSB first
  input wire logic send,
  input wire logic [15:0] frame,
  input wire logic [4:0] flen,
  input wire logic rts_n,
  output logic rxd,
  output logic sbusy,
  // Capture of device frames
  input wire logic txd,
  input wire logic [4:0] rbits,
  output logic [15:0] cap,
  output logic [7:0] cap_cnt
);
  logic [16:0] shift;
  logic [15:0] acc;
  logic txd_q, cap_on;
  int s_t, s_n, c_t, c_i;

  ////////////////////////////////
  // Sender honours request-to-send
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxd <= 1'b1;
      sbusy <= 1'b0;
      shift <= '1;
      s_t <= 0;
      s_n <= 0;
    end else if (!sbusy) begin
      rxd <= 1'b1;
      if (send && !rts_n) begin
        shift <= {frame, 1'b0};
        s_n <= int'(flen) + 1;
        s_t <= 0;
        sbusy <= 1'b1;
      end
    end else begin
      rxd <= shift[0];
      s_t <= (s_t == BIT_CLKS - 1) ? 0 : s_t + 1;
      if (s_t == BIT_CLKS - 1) begin
        shift <= {1'b1, shift[16:1]};
        s_n <= s_n - 1;
        sbusy <= (s_n != 1);
      end
    end
  end

  ////////////////////////////////
  // Capture: start edge, then mid-bit samples
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txd_q <= 1'b1;
      cap_on <= 1'b0;
      acc <= '0;
      cap <= '0;
      cap_cnt <= '0;
      c_t <= 0;
      c_i <= 0;
    end else begin
      txd_q <= txd;
      if (!cap_on) begin
        cap_on <= txd_q && !txd;
        c_t <= BIT_CLKS + BIT_CLKS / 2 - 2;
        c_i <= 0;
        acc <= '0;
      end else if (c_t != 0) begin
        c_t <= c_t - 1;
      end else begin
        acc[4'(c_i)] <= txd;
        c_i <= c_i + 1;
        c_t <= BIT_CLKS - 1;
        if (c_i == int'(rbits) - 1) begin
          cap_on <= 1'b0;
          cap <= acc | (16'(txd) << c_i);
          cap_cnt <= cap_cnt + 8'h01;
        end
      end
    end
  end
endmodule : uas_remote

//--- test/uas_top_bench.sv
/*
  Bench of the transceiver: scenario tasks against the remote.
  Assumes uas_map.svh on the include path; divider zero.
*/
`include "uas_map.svh"
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module uas_top_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, resetn, tx_valid, rx_ready, err_clr, cts_n, dsr_n, dcd_n, ri_n;
  logic tx_ready, rx_valid, tx_dma_req, rx_dma_req, rx_timeout, rx_overrun;
  logic line_err, tx_busy, txd, rts_n, rxd, send, sbusy;
  logic [7:0] tx_data, cap_cnt;
  logic [10:0] rx_data;
  logic [3:0] modem_status;
  logic [15:0] frame, cap;
  logic [4:0] flen, rbits;
  uas_pkg::uas_cfg_type cfg;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;

  uas_top dut (
    .clk(clk), .resetn(resetn), .cfg(cfg), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .rx_timeout(rx_timeout),
    .rx_overrun(rx_overrun), .line_err(line_err), .err_clr(err_clr),
    .modem_status(modem_status), .tx_busy(tx_busy), .rxd(rxd), .txd(txd), .cts_n(cts_n),
    .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .rts_n(rts_n)
  );
  uas_remote remote (
    .clk(clk), .resetn(resetn), .send(send), .frame(frame), .flen(flen), .rts_n(rts_n),
    .rxd(rxd), .sbusy(sbusy), .txd(txd), .rbits(rbits), .cap(cap), .cap_cnt(cap_cnt)
  );

  ////////////////////////////////
  // Clock and cycle ceiling
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      fails++;
      complete_run();
    end
  end

  ////////////////////////////////
  // Shared steps
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic push_tx(input logic [7:0] d);
    int k;
    tx_valid = 1'b1;
    tx_data = d;
    for (k = 0; k < 8 && tx_ready !== 1'b1; k++) tick(1);
    tick(1);
    tx_valid = 1'b0;
    tick(1);
  endtask : push_tx

  task automatic wait_cap(input logic [7:0] c);
    int k;
    for (k = 0; k < 600 && cap_cnt === c; k++) tick(1);
  endtask : wait_cap

  // Hold send until the remote starts
  task automatic remote_send(input logic [15:0] f, input logic [4:0] n);
    int k;
    frame = f;
    flen = n;
    send = 1'b1;
    for (k = 0; k < 50 && sbusy !== 1'b1; k++) tick(1);
    send = 1'b0;
    for (k = 0; k < 400 && sbusy === 1'b1; k++) tick(1);
    tick(2);
  endtask : remote_send

  task automatic pop_chk(input logic [10:0] e);
    int k;
    for (k = 0; k < 40 && rx_valid !== 1'b1; k++) tick(1);
    `CHK("rx entry", e, rx_data)
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask : pop_chk

  // Eight data bits, even parity, two stop bits
  function automatic logic [15:0] frame_of(input logic [7:0] d, input logic badp, input logic bads);
    frame_of = {5'h1F, 1'b1, ~bads, ^d ^ badp, d};
  endfunction : frame_of

  ////////////////////////////////
  // Scenarios
  task automatic modem_lines;
    int k;
    logic [3:0] p;
    for (k = 0; k < 2; k++) begin
      p = k ? 4'hA : 4'h5;
      {ri_n, dcd_n, dsr_n, cts_n} = p;
      tick(5);
      `CHK("modem status", ~p, modem_status)
    end
  endtask : modem_lines

  // All word lengths, both parities; high bits dropped
  task automatic tx_frames;
    int i, n;
    logic [7:0] d, c;
    logic [15:0] e;
    for (i = 0; i < 8; i++) begin
      n = 5 + i % 4;
      cfg.word_len = 2'(i);
      cfg.parity_en = i[2];
      cfg.parity_even = i[0];
      d = 8'hA5 & 8'((1 << n) - 1);
      e = {8'h00, d} | (16'(i[2] & (i[0] ? ^d : ~^d)) << n) | (16'h1 << (n + i[2]));
      rbits = 5'(n + i[2] + 1);
      c = cap_cnt;
      push_tx(8'hA5);
      wait_cap(c);
      `CHK("tx frame", e, cap)
      tick(40);
    end
  endtask : tx_frames

  task automatic rx_entries;
    cfg.word_len = 2'h3;
    cfg.parity_en = 1'b1;
    cfg.parity_even = 1'b1;
    cfg.flow_en = 1'b1;
    remote_send(frame_of(8'h3C, 1'b1, 1'b0), 5'hB);
    tick(4);
    `CHK("rts held", 1'b1, rts_n)
    pop_chk(11'h03C);
    `CHK("line err", 1'b1, line_err)
    err_clr = 1'b1;
    tick(1);
    err_clr = 1'b0;
    tick(4);
    `CHK("err clear", 1'b0, line_err)
    `CHK("rts ready", 1'b0, rts_n)
    cfg.flow_en = 1'b0;
    cfg.fifo_mode = 1'b1;
    remote_send(frame_of(8'h3C, 1'b0, 1'b0), 5'hB);
    pop_chk(11'h03C);
    remote_send(frame_of(8'hC3, 1'b1, 1'b0), 5'hB);
    pop_chk(11'h1C3);
    remote_send(frame_of(8'h5A, 1'b0, 1'b1), 5'hB);
    pop_chk(11'h25A);
    remote_send(16'h0000, 5'h10);
    pop_chk(11'h600);
  endtask : rx_entries

  // Four-frame gap, then one entry past depth
  task automatic timeout_fill;
    int k;
    remote_send(frame_of(8'h11, 1'b0, 1'b0), 5'hB);
    tick(700);
    `CHK("early timeout", 1'b0, rx_timeout)
    tick(100);
    `CHK("timeout", 1'b1, rx_timeout)
    for (k = 0; k < `UAS_RX_DEPTH; k++) remote_send(frame_of(8'(k), 1'b0, 1'b0), 5'hB);
    `CHK("overrun", 1'b1, rx_overrun)
    `CHK("rx dma", 1'b1, rx_dma_req)
    pop_chk(11'h011);
    tick(1);
    `CHK("timeout clear", 1'b0, rx_timeout)
    for (k = 0; k < `UAS_RX_DEPTH - 1; k++) pop_chk(11'(k));
    tick(2);
    `CHK("rx drained", 1'b0, rx_valid)
  endtask : timeout_fill

  // CTS off: queue fills, line idle
  task automatic flow_depth;
    int m, k, n;
    logic hold_ok;
    logic [7:0] c;
    cfg.parity_en = 1'b0;
    cfg.flow_en = 1'b1;
    cts_n = 1'b1;
    rbits = 5'hA;
    for (m = 0; m < 2; m++) begin
      cfg.fifo_mode = (m == 0);
      tick(4);
      n = 0;
      hold_ok = 1'b1;
      tx_valid = 1'b1;
      tx_data = 8'h5A;
      for (k = 0; k < 60; k++) begin
        n += int'(tx_ready === 1'b1);
        hold_ok &= (txd === 1'b1);
        tick(1);
      end
      tx_valid = 1'b0;
      `CHK("queue depth", (m == 0) ? `UAS_TX_DEPTH : 1, n)
      `CHK("held line", 1'b1, hold_ok)
      c = cap_cnt;
      cts_n = 1'b0;
      wait_cap(c);
      `CHK("released frame", 16'h035A, cap)
      for (k = 0; k < 8000 && tx_busy !== 1'b0; k++) tick(1);
      cts_n = 1'b1;
    end
    cfg.flow_en = 1'b0;
  endtask : flow_depth

  task automatic ir_pulses;
    int j, k, w;
    cfg.ir_en = 1'b1;
    for (j = 0; j < 2; j++) begin
      cfg.ir_pulse4 = j[0];
      tick(4);
      `CHK("ir idle", 1'b0, txd)
      push_tx(8'h00);
      for (k = 0; k < 100 && txd !== 1'b1; k++) tick(1);
      for (w = 0; w < 40 && txd === 1'b1; w++) tick(1);
      `CHK("ir pulse", 3 + j, w)
      for (k = 0; k < 400 && tx_busy !== 1'b0; k++) tick(1);
    end
  endtask : ir_pulses

  ////////////////////////////////
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // Main sequence, legacy 8N2
  initial begin
    resetn = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b0;
    err_clr = 1'b0;
    {ri_n, dcd_n, dsr_n, cts_n} = 4'hF;
    send = 1'b0;
    frame = 16'hFFFF;
    flen = 5'h0;
    rbits = 5'h9;
    cfg = '0;
    cfg.word_len = 2'h3;
    cfg.stop2 = 1'b1;
    cfg.rts_force = 1'b1;
    repeat (10) @(posedge clk);
    `CHK("reset txd", 1'b1, txd)
    `CHK("reset rts", 1'b1, rts_n)
    `CHK("reset ready", 1'b0, tx_ready)
    #1 resetn = 1'b1;
    tick(3);
    `CHK("ready after reset", 1'b1, tx_ready)
    modem_lines();
    tx_frames();
    rx_entries();
    timeout_fill();
    flow_depth();
    ir_pulses();
    complete_run();
  end
endmodule : uas_top_bench
